/* File: pkg/psc_map.svh */
// Constants for the 16-bit card control-signal block.
// Assumes inclusion by bare name from package and design files.
`ifndef PSC_MAP_SVH
`define PSC_MAP_SVH
`define PSC_STROBE_CYCLES 2
`define PSC_CMD_MEM_READ 3'h0
`define PSC_CMD_MEM_WRITE 3'h1
`define PSC_CMD_IO_READ 3'h2
`define PSC_CMD_IO_WRITE 3'h3
`define PSC_CMD_DMA_TO_HOST 3'h4
`define PSC_CMD_DMA_TO_CARD 3'h5
`endif

/* File: pkg/psc_pkg.sv */
// Types for the 16-bit card control-signal block.
// Assumes psc_map.svh is on the include path.
`include "psc_map.svh"
package psc_pkg;
    typedef enum logic [1:0] {
        psc_idle,
        psc_strobe
    } psc_state_t;

    typedef struct packed {
        psc_state_t state;
        logic [7:0] count;
        logic [2:0] cmd;
        logic last;
        logic done;
        logic present;
        logic [1:0] detect;
        logic ready;
        logic irq;
        logic even_byte_select_n;
        logic odd_byte_select_n;
        logic mem_output_enable_n;
        logic mem_write_enable_n;
        logic io_read_strobe_n;
        logic io_write_strobe_n;
        logic attribute_select_n;
    } psc_regs_t;
endpackage : psc_pkg

/* File: hw/psc_ctrl.sv */
// Control-signal sequencer for one 16-bit card socket.
// Assumes card inputs are synchronous to clk; one request at a time when busy is low.
`timescale 1ns/1ps
`default_nettype none
`include "psc_map.svh"
module psc_ctrl #(
    parameter int STROBE_CYCLES = `PSC_STROBE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire logic [2:0] req_cmd,
    input wire logic req_attr,
    input wire logic req_even,
    input wire logic req_odd,
    input wire logic req_last,
    input wire logic io_mode,
    input wire logic detect_line_one_n,
    input wire logic detect_line_two_n,
    input wire logic ready_irq_in,
    input wire logic input_acknowledge_n,
    output logic busy,
    output logic done,
    output logic card_present,
    output logic [1:0] detect_status,
    output logic mem_ready,
    output logic card_interrupt_request,
    output logic dma_request,
    output logic io_read_ack,
    output logic even_byte_select_n,
    output logic odd_byte_select_n,
    output logic mem_output_enable_n,
    output logic mem_write_enable_n,
    output logic io_read_strobe_n,
    output logic io_write_strobe_n,
    output logic attribute_select_n
);
    initial begin
        // The strobe counter is eight bits wide
        if (STROBE_CYCLES < 1) begin
            $error("STROBE_CYCLES below one");
        end
        if (STROBE_CYCLES > 255) begin
            $error("STROBE_CYCLES above counter range");
        end
    end

    // Idle levels: every card strobe and select deasserted
    localparam psc_pkg::psc_regs_t REGS_AT_RESET = '{
        state: psc_pkg::psc_idle,
        count: 8'h00,
        cmd: 3'h0,
        last: 1'b0,
        done: 1'b0,
        present: 1'b0,
        detect: 2'h3,
        ready: 1'b0,
        irq: 1'b0,
        even_byte_select_n: 1'b1,
        odd_byte_select_n: 1'b1,
        mem_output_enable_n: 1'b1,
        mem_write_enable_n: 1'b1,
        io_read_strobe_n: 1'b1,
        io_write_strobe_n: 1'b1,
        attribute_select_n: 1'b1
    };

    psc_pkg::psc_regs_t r;
    psc_pkg::psc_regs_t next_r;
    logic busy_q;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        // Status follows the card pins one cycle late
        next_r.detect = {detect_line_two_n, detect_line_one_n};
        next_r.present = !detect_line_one_n && !detect_line_two_n;
        next_r.ready = !io_mode && ready_irq_in;
        next_r.irq = io_mode && !ready_irq_in;
        case (r.state)
            psc_pkg::psc_idle: begin
                // Start every access from idle levels so nothing lingers
                next_r.even_byte_select_n = 1'b1;
                next_r.odd_byte_select_n = 1'b1;
                next_r.mem_output_enable_n = 1'b1;
                next_r.mem_write_enable_n = 1'b1;
                next_r.io_read_strobe_n = 1'b1;
                next_r.io_write_strobe_n = 1'b1;
                next_r.attribute_select_n = 1'b1;
                if (req_valid) begin
                    next_r.state = psc_pkg::psc_strobe;
                    next_r.count = 8'(STROBE_CYCLES - 1);
                    next_r.cmd = req_cmd;
                    next_r.last = req_last;
                    next_r.even_byte_select_n = !req_even;
                    next_r.odd_byte_select_n = !req_odd;
                    // One strobe per access, except output enable with the I/O read strobe on a last DMA-to-host transfer
                    case (req_cmd)
                        // Host memory read, common or attribute space
                        `PSC_CMD_MEM_READ: begin
                            next_r.mem_output_enable_n = 1'b0;
                            next_r.attribute_select_n = !req_attr;
                        end
                        // Host memory write, common or attribute space
                        `PSC_CMD_MEM_WRITE: begin
                            next_r.mem_write_enable_n = 1'b0;
                            next_r.attribute_select_n = !req_attr;
                        end
                        // Host I/O read; attribute select marks I/O space
                        `PSC_CMD_IO_READ: begin
                            next_r.io_read_strobe_n = 1'b0;
                            next_r.attribute_select_n = 1'b0;
                        end
                        // Host I/O write; attribute select marks I/O space
                        `PSC_CMD_IO_WRITE: begin
                            next_r.io_write_strobe_n = 1'b0;
                            next_r.attribute_select_n = 1'b0;
                        end
                        // DMA card to host; output enable doubles as terminal count
                        `PSC_CMD_DMA_TO_HOST: begin
                            next_r.io_read_strobe_n = 1'b0;
                            next_r.attribute_select_n = 1'b0;
                            next_r.mem_output_enable_n = !req_last;
                        end
                        // DMA host to card
                        `PSC_CMD_DMA_TO_CARD: begin
                            next_r.io_write_strobe_n = 1'b0;
                            next_r.attribute_select_n = 1'b0;
                        end
                        // Unused codes finish at once with no strobe
                        default: begin
                            next_r.state = psc_pkg::psc_idle;
                            next_r.done = 1'b1;
                        end
                    endcase
                end
            end
            psc_pkg::psc_strobe: begin
                if (r.count == 8'h00) begin
                    next_r.state = psc_pkg::psc_idle;
                    next_r.done = 1'b1;
                    next_r.even_byte_select_n = 1'b1;
                    next_r.odd_byte_select_n = 1'b1;
                    next_r.mem_output_enable_n = 1'b1;
                    next_r.mem_write_enable_n = 1'b1;
                    next_r.io_read_strobe_n = 1'b1;
                    next_r.io_write_strobe_n = 1'b1;
                    next_r.attribute_select_n = 1'b1;
                end else begin
                    next_r.count = r.count - 8'h01;
                end
            end
            default: begin
                next_r.state = psc_pkg::psc_idle;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= REGS_AT_RESET;
        end else begin
            r <= next_r;
        end
    end

    logic dma_req_q;
    logic io_ack_q;

    // Input acknowledge is the card's DMA request, during reads as well
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dma_req_q <= 1'b0;
        end else begin
            dma_req_q <= !input_acknowledge_n;
        end
    end

    // Acknowledge only counts while our read strobe is out
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            io_ack_q <= 1'b0;
        end else begin
            io_ack_q <= !input_acknowledge_n && !r.io_read_strobe_n;
        end
    end

    // Busy has its own flop so the port comes straight from a register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (next_r.state != psc_pkg::psc_idle);
        end
    end

    // Status and handshake outputs
    assign busy = busy_q;

    assign done = r.done;
    assign card_present = r.present;
    assign detect_status = r.detect;
    assign mem_ready = r.ready;
    assign card_interrupt_request = r.irq;
    assign dma_request = dma_req_q;
    assign io_read_ack = io_ack_q;

    // Card-side strobes and selects, all active low
    assign even_byte_select_n = r.even_byte_select_n;
    assign odd_byte_select_n = r.odd_byte_select_n;
    assign mem_output_enable_n = r.mem_output_enable_n;
    assign mem_write_enable_n = r.mem_write_enable_n;
    assign io_read_strobe_n = r.io_read_strobe_n;
    assign io_write_strobe_n = r.io_write_strobe_n;
    assign attribute_select_n = r.attribute_select_n;
endmodule : psc_ctrl
`default_nettype wire

/* File: verification/psc_ctrl_assertions.sv */
// Port-level checks of psc_ctrl strobes and status.
// Bound to psc_ctrl; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module psc_ctrl_assertions #(parameter int STROBE_CYCLES = 2) (
    input wire logic clk, rst_b, req_valid, req_attr, req_even, req_odd, req_last,
    input wire logic io_mode, detect_line_one_n, detect_line_two_n, ready_irq_in,
    input wire logic [2:0] req_cmd,
    input wire logic busy, done, card_present, mem_ready, card_interrupt_request,
    input wire logic even_byte_select_n, odd_byte_select_n, mem_output_enable_n,
    input wire logic mem_write_enable_n, io_read_strobe_n, io_write_strobe_n,
    input wire logic attribute_select_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic take;
    assign take = req_valid && !busy;
    sequence s_pulse(s);
        !s ##STROBE_CYCLES (s && done);
    endsequence
    a_card_present: assert property ($past(rst_b) |-> card_present ==
        $past(!detect_line_one_n && !detect_line_two_n)) else $error("present");
    a_byte_sel: assert property (take && req_cmd < 3'h6 |=>
        even_byte_select_n == !$past(req_even) && odd_byte_select_n == !$past(req_odd))
        else $error("byte select");
    a_io_read: assert property (take && req_cmd inside {3'h2, 3'h4} |=>
        s_pulse(io_read_strobe_n)) else $error("io read");
    a_io_write: assert property (take && req_cmd inside {3'h3, 3'h5} |=>
        s_pulse(io_write_strobe_n)) else $error("io write");
    a_mem_read: assert property (take && req_cmd == 3'h0 |=>
        s_pulse(mem_output_enable_n)) else $error("mem read");
    a_mem_write: assert property (take && req_cmd == 3'h1 |=>
        s_pulse(mem_write_enable_n)) else $error("mem write");
    a_term_count: assert property (take && req_cmd == 3'h4 && req_last |=>
        s_pulse(mem_output_enable_n)) else $error("terminal count");
    a_attr_common: assert property (take && req_cmd < 3'h2 && !req_attr |=>
        attribute_select_n [*2]) else $error("attr common");
    a_attr_space: assert property (take && req_cmd inside {[3'h0:3'h5]} |=>
        attribute_select_n == ($past(req_cmd) < 3'h2 && !$past(req_attr))) else $error("attr");
    a_no_mix: assert property (!(!mem_write_enable_n &&
        !(io_read_strobe_n && io_write_strobe_n)) && !(!mem_output_enable_n &&
        !io_write_strobe_n)) else $error("mixed strobes");
    a_ready_mode: assert property ($past(rst_b) |->
        mem_ready == $past(!io_mode && ready_irq_in) &&
        card_interrupt_request == $past(io_mode && !ready_irq_in)) else $error("mode");
endmodule : psc_ctrl_assertions
bind psc_ctrl psc_ctrl_assertions #(.STROBE_CYCLES(STROBE_CYCLES)) u_chk (.*);
`default_nettype wire

/* File: verification/psc_card.sv */
// Behavioural 16-bit card beside psc_ctrl.
// Bench sets insertion, busy, interrupt and DMA wishes.
`timescale 1ns/1ps
`default_nettype none
module psc_card (
    input wire logic inserted, io_mode, busy_card, irq_req, dma_req, io_read_strobe_n,
    output logic detect_line_one_n, detect_line_two_n, ready_irq_in, input_acknowledge_n
);
    assign detect_line_one_n = !inserted;
    assign detect_line_two_n = !inserted;
    assign ready_irq_in = io_mode ? !irq_req : !busy_card;
    assign input_acknowledge_n = !(dma_req || !io_read_strobe_n);
endmodule : psc_card
`default_nettype wire

/* File: verification/testbench.sv */
// Self-checking bench for psc_ctrl with a card model.
// Strobe length fixed at 2 cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, rst_b = 0, req_valid = 0, req_attr = 0, req_even = 0, req_odd = 0;
    logic req_last = 0, io_mode = 0, inserted = 0, busy_card = 0, irq_req = 0, dma_req = 0;
    logic [2:0] req_cmd = 3'h0;
    logic detect_line_one_n, detect_line_two_n, ready_irq_in, input_acknowledge_n;
    logic busy, done, card_present, mem_ready, card_interrupt_request, dma_request;
    logic io_read_ack, even_byte_select_n, odd_byte_select_n, mem_output_enable_n;
    logic mem_write_enable_n, io_read_strobe_n, io_write_strobe_n, attribute_select_n;
    logic [1:0] detect_status;
    logic [4:0] strb;
    logic [31:0] r;
    int err_total = 0, n_tests = 0;
    assign strb = {mem_output_enable_n, mem_write_enable_n, io_read_strobe_n,
        io_write_strobe_n, attribute_select_n};
    always #10 clk = ~clk;
    psc_ctrl #(.STROBE_CYCLES(2)) DUT (.*);
    psc_card u_card (.*);
    task automatic chk(input string n, input logic [7:0] s, x);
        n_tests++;
        if (s !== x) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    function automatic logic [4:0] exp_s(input logic [2:0] c, input logic a, l);
        case (c)
            3'h0: return {4'h7, !a};
            3'h1: return {4'hb, !a};
            3'h2: return 5'h1a;
            3'h4: return {!l, 4'ha};
            3'h3, 3'h5: return 5'h1c;
            default: return 5'h1f;
        endcase
    endfunction : exp_s
    task automatic acc(input logic [2:0] c, input logic a, e, o, l);
        int k;
        @(negedge clk);
        {req_valid, req_cmd, req_attr, req_even, req_odd, req_last} = {1'b1, c, a, e, o, l};
        @(negedge clk);
        req_valid = 0;
        k = 0;
        while (done !== 1'b1 && k < 8) begin
            chk("strobes", strb, exp_s(c, a, l));
            chk("selects", {even_byte_select_n, odd_byte_select_n}, {!e, !o});
            chk("io_ack", io_read_ack, k == 1 && (c == 3'h2 || c == 3'h4));
            @(negedge clk);
            k++;
        end
        chk("length", k, c > 3'h5 ? 0 : 2);
        chk("idle", {done, strb}, 6'h3f);
    endtask : acc
    initial begin
        void'($urandom(32'hdc64_90f8));
        repeat (6) @(negedge clk);
        rst_b = 1;
        for (int i = 0; i < 32; i++) begin
            {inserted, io_mode, busy_card, irq_req, dma_req} = i[4:0];
            repeat (2) @(negedge clk);
            chk("present", {card_present, detect_status}, {inserted, {2{!inserted}}});
            chk("ready", mem_ready, !io_mode && !busy_card);
            chk("irq", card_interrupt_request, io_mode && irq_req);
            chk("dma_req", dma_request, dma_req);
        end
        $display("Status test done");
        {inserted, io_mode, busy_card, irq_req, dma_req} = 5'h10;
        for (int i = 0; i < 8; i++) acc(i[2:0], 1'b1, 1'b0, 1'b1, 1'b1);
        for (int i = 0; i < 60; i++) begin
            r = $urandom;
            acc(r[2:0], r[3], r[4], r[5], r[6]);
        end
        $display("Access test done");
        wrap_up();
    end
    initial begin
        #40000;
        err_total++;
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
